/* File: core/pfs_top.v */
// pin function select, test multiplexer and push-button wake
//
// The plain strobed port and the register offsets were decided locally.
`timescale 1ns/1ns
`include "pfs_regs.vh"
// Operation
// - emulator enable picks emulator port or segments
// - enable bits pick clock/sync or segment
// - four-bit field routes test multiplexer output
// - optical receive: uart input or general io
// - optical transmit: led output or general io
// - active-high reset forces known state
// - button rising edge sets event flag
// - button edge wakes from sleep/lcd-only
module pfs_top (
  // clock and reset
  input wire clk,
  input wire rst,
  // register port
  input wire [`PFS_ADDR_W-1:0] addr,
  input wire [7:0] wdata,
  input wire wr,
  input wire rd,
  output reg [7:0] rdata,
  // interrupt
  output reg irq,
  // emulator pins: data, clock, reset lines
  input wire emulator_enable_pin,
  input wire emulator_data_in,
  input wire emulator_data_out,
  input wire emulator_data_oe_n,
  input wire emulator_clock_out,
  input wire emulator_reset_out,
  output reg [2:0] emu_pin_out,
  output reg [2:0] emu_pin_oe_n,
  output reg emulator_data_rx,
  // lcd segments sharing pins: 9,10,11 then 19,7
  input wire [2:0] lcd_seg_emu,
  input wire lcd_seg_19,
  input wire lcd_seg_7,
  // clock test and frame sync
  input wire test_clock,
  input wire frame_sync,
  output reg clock_test_output,
  output reg multiplexer_frame_sync_output,
  // test multiplexer
  input wire [15:0] test_sources,
  output reg test_selector_pin,
  // optical receive pin
  input wire optical_receive_pin,
  output reg optical_receive_out,
  output reg optical_receive_oe_n,
  output reg uart_rx,
  // optical transmit pin
  input wire uart_tx_led,
  input wire optical_transmit_pin,
  output reg optical_transmit_out,
  output reg optical_transmit_oe_n,
  // push button and wake
  input wire push_button_input,
  output reg wake
);
  // control and selector registers
  reg [`PFS_CTRL_W-1:0] ctrl;
  reg [`PFS_CTRL_W-1:0] next_ctrl;
  reg [`PFS_TSEL_W-1:0] test_selector_field;
  reg [1:0] dio_out;
  reg [1:0] dio_dir;
  // event flags, their enables and the button history
  reg [`PFS_ST_W-1:0] status;
  reg [`PFS_ST_W-1:0] next_status;
  reg [`PFS_ST_W-1:0] irq_en;
  reg button_q;
  // next values of the read port and the pins
  reg [7:0] next_rdata;
  reg [2:0] next_emu_oe_n;
  reg next_rx_out;
  reg next_rx_oe_n;
  reg next_uart_rx;
  reg next_tx_out;
  reg next_tx_oe_n;
  // control fields
  wire clock_output_enable_bit;
  wire multiplexer_sync_enable_bit;
  wire rx_as_dio;
  wire tx_as_dio;
  wire low_power;
  // synchronised pins
  wire emu_en;
  wire button_s;
  wire [1:0] dio_in_s;
  // events and pin selections
  wire button_rise;
  wire wake_event;
  wire [`PFS_ST_W-1:0] set_mask;
  wire [`PFS_ST_W-1:0] clear_mask;
  wire [2:0] emu_mux;
  wire [1:0] ck_mux;
  // one write strobe per register
  wire wr_ctrl;
  wire wr_tsel;
  wire wr_dio_out;
  wire wr_dio_dir;
  wire wr_clear;
  wire wr_irq_en;

  assign clock_output_enable_bit = ctrl[`PFS_CTRL_CKOUT];
  assign multiplexer_sync_enable_bit = ctrl[`PFS_CTRL_MULTIPLEXER_FRAME_SYNC_OUTPUT];
  assign rx_as_dio = ctrl[`PFS_CTRL_RX_DIO];
  assign tx_as_dio = ctrl[`PFS_CTRL_TX_DIO];
  assign low_power = ctrl[`PFS_CTRL_SLEEP] | ctrl[`PFS_CTRL_LCDONLY];

  // status and unmapped offsets take no write
  assign wr_ctrl = wr && (addr == `PFS_OFF_CTRL);
  assign wr_tsel = wr && (addr == `PFS_OFF_TSEL);
  assign wr_dio_out = wr && (addr == `PFS_OFF_DIO_OUT);
  assign wr_dio_dir = wr && (addr == `PFS_OFF_DIO_DIR);
  assign wr_clear = wr && (addr == `PFS_OFF_CLEAR);
  assign wr_irq_en = wr && (addr == `PFS_OFF_IRQ_EN);

  // emulator enable, button and optical pins pass two flops before use
  pfs_sync2 #(.W(1)) u_sync_emu (
    .clk(clk),
    .rst(rst),
    .d(emulator_enable_pin),
    .q(emu_en)
  );
  pfs_sync2 #(.W(1)) u_sync_btn (
    .clk(clk),
    .rst(rst),
    .d(push_button_input),
    .q(button_s)
  );
  pfs_sync2 #(.W(2)) u_sync_dio (
    .clk(clk),
    .rst(rst),
    .d({optical_transmit_pin, optical_receive_pin}),
    .q(dio_in_s)
  );

  // emulator port or lcd segments 9..11
  pfs_pin_mux #(.W(3)) u_mux_emu (
    .sel_primary({3{emu_en}}),
    .primary({emulator_reset_out, emulator_clock_out, emulator_data_out}),
    .segment(lcd_seg_emu),
    .y(emu_mux)
  );
  // clock test on segment 19, frame sync on segment 7
  pfs_pin_mux #(.W(2)) u_mux_ck (
    .sel_primary({multiplexer_sync_enable_bit, clock_output_enable_bit}),
    .primary({frame_sync, test_clock}),
    .segment({lcd_seg_7, lcd_seg_19}),
    .y(ck_mux)
  );

  // no false edge after reset: the pin idles low and button_q clears low
  assign button_rise = button_s & ~button_q;
  // every press in a low-power state wakes, whatever the sticky flag holds
  assign wake_event = button_rise & low_power;
  assign set_mask = {wake_event, button_rise};
  assign clear_mask = wr_clear ? wdata[`PFS_ST_W-1:0] : {`PFS_ST_W{1'b0}};

  // hardware set wins over a same-cycle software clear
  always @* begin
    next_status = (status & ~clear_mask) | set_mask;
  end

  // a wake leaves the sleep and lcd-only states, even against a write
  always @* begin
    next_ctrl = ctrl;
    if (wr_ctrl) begin
      next_ctrl = wdata[`PFS_CTRL_W-1:0];
    end
    if (wake_event) begin
      next_ctrl[`PFS_CTRL_SLEEP] = 1'b0;
      next_ctrl[`PFS_CTRL_LCDONLY] = 1'b0;
    end
  end

  // emulator data line turns around; clock and reset lines only drive
  always @* begin
    if (emu_en) begin
      next_emu_oe_n = {2'b00, emulator_data_oe_n};
    end else begin
      next_emu_oe_n = 3'h0;
    end
  end

  // uart sees an idle line while the pin serves as general io
  always @* begin
    if (rx_as_dio) begin
      next_rx_out = dio_out[0];
      next_rx_oe_n = ~dio_dir[0];
      next_uart_rx = 1'b1;
    end else begin
      next_rx_out = 1'b0;
      next_rx_oe_n = 1'b1;
      next_uart_rx = dio_in_s[0];
    end
  end

  // led path always drives; general io drives only by direction bit
  always @* begin
    if (tx_as_dio) begin
      next_tx_out = dio_out[1];
      next_tx_oe_n = ~dio_dir[1];
    end else begin
      next_tx_out = uart_tx_led;
      next_tx_oe_n = 1'b0;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      ctrl <= `PFS_CTRL_RST;
    end else begin
      ctrl <= next_ctrl;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      test_selector_field <= `PFS_TSEL_RST;
    end else if (wr_tsel) begin
      test_selector_field <= wdata[`PFS_TSEL_W-1:0];
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      dio_out <= `PFS_DIO_RST;
    end else if (wr_dio_out) begin
      dio_out <= wdata[1:0];
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      dio_dir <= `PFS_DIO_RST;
    end else if (wr_dio_dir) begin
      dio_dir <= wdata[1:0];
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      irq_en <= `PFS_ST_RST;
    end else if (wr_irq_en) begin
      irq_en <= wdata[`PFS_ST_W-1:0];
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      status <= `PFS_ST_RST;
      button_q <= 1'b0;
    end else begin
      status <= next_status;
      button_q <= button_s;
    end
  end

  // interrupt is a level; wake is a one-cycle pulse per waking press
  always @(posedge clk) begin
    if (rst) begin
      irq <= 1'b0;
      wake <= 1'b0;
    end else begin
      irq <= |(next_status & irq_en);
      wake <= wake_event;
    end
  end

  // read data stand for the one cycle after the strobe, zero otherwise
  always @(posedge clk) begin
    if (rst) begin
      rdata <= 8'h00;
    end else if (rd) begin
      rdata <= next_rdata;
    end else begin
      rdata <= 8'h00;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      emu_pin_out <= 3'h0;
      emu_pin_oe_n <= 3'h7;
      emulator_data_rx <= 1'b0;
    end else begin
      emu_pin_out <= emu_mux;
      emu_pin_oe_n <= next_emu_oe_n;
      emulator_data_rx <= emu_en & emulator_data_in;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      clock_test_output <= 1'b0;
      multiplexer_frame_sync_output <= 1'b0;
    end else begin
      clock_test_output <= ck_mux[0];
      multiplexer_frame_sync_output <= ck_mux[1];
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      test_selector_pin <= 1'b0;
    end else begin
      test_selector_pin <= test_sources[test_selector_field];
    end
  end

  // pins float until reset ends so nothing fights the board
  always @(posedge clk) begin
    if (rst) begin
      optical_receive_out <= 1'b0;
      optical_receive_oe_n <= 1'b1;
      uart_rx <= 1'b1;
    end else begin
      optical_receive_out <= next_rx_out;
      optical_receive_oe_n <= next_rx_oe_n;
      uart_rx <= next_uart_rx;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      optical_transmit_out <= 1'b0;
      optical_transmit_oe_n <= 1'b1;
    end else begin
      optical_transmit_out <= next_tx_out;
      optical_transmit_oe_n <= next_tx_oe_n;
    end
  end

  always @* begin
    case (addr)
      `PFS_OFF_CTRL: next_rdata = {{(8-`PFS_CTRL_W){1'b0}}, ctrl};
      `PFS_OFF_TSEL: next_rdata = {{(8-`PFS_TSEL_W){1'b0}}, test_selector_field};
      `PFS_OFF_DIO_OUT: next_rdata = {6'h00, dio_out};
      `PFS_OFF_DIO_DIR: next_rdata = {6'h00, dio_dir};
      `PFS_OFF_DIO_IN: next_rdata = {6'h00, dio_in_s};
      `PFS_OFF_STATUS: next_rdata = {{(8-`PFS_ST_W){1'b0}}, status};
      `PFS_OFF_IRQ_EN: next_rdata = {{(8-`PFS_ST_W){1'b0}}, irq_en};
      `PFS_OFF_WAKE: next_rdata = {7'h00, emu_en};
      default: next_rdata = 8'h00;
    endcase
  end
endmodule

/* File: core/pfs_regs.vh */
// register offsets, field positions and reset values of the pin function block
`ifndef PFS_REGS_VH
`define PFS_REGS_VH
`define PFS_ADDR_W 4
`define PFS_OFF_CTRL 4'h0
`define PFS_OFF_TSEL 4'h1
`define PFS_OFF_DIO_OUT 4'h2
`define PFS_OFF_DIO_DIR 4'h3
`define PFS_OFF_DIO_IN 4'h4
`define PFS_OFF_STATUS 4'h5
`define PFS_OFF_CLEAR 4'h6
`define PFS_OFF_IRQ_EN 4'h7
`define PFS_OFF_WAKE 4'h8
`define PFS_CTRL_CKOUT 0
`define PFS_CTRL_MULTIPLEXER_FRAME_SYNC_OUTPUT 1
`define PFS_CTRL_RX_DIO 2
`define PFS_CTRL_TX_DIO 3
`define PFS_CTRL_SLEEP 4
`define PFS_CTRL_LCDONLY 5
`define PFS_CTRL_W 6
`define PFS_CTRL_RST 6'h00
`define PFS_TSEL_W 4
`define PFS_TSEL_RST 4'h0
`define PFS_DIO_RST 2'h0
`define PFS_ST_BUTTON 0
`define PFS_ST_WAKE 1
`define PFS_ST_W 2
`define PFS_ST_RST 2'h0
`endif

/* File: core/pfs_sync2.v */
// two-stage synchroniser for a level from outside the clock domain
`timescale 1ns/1ns
module pfs_sync2 #(
  parameter W = 1
) (
  // clock and reset
  input wire clk,
  input wire rst,
  // level in and out
  input wire [W-1:0] d,
  output reg [W-1:0] q
);
  reg [W-1:0] meta;
  always @(posedge clk) begin
    if (rst) begin
      meta <= {W{1'b0}};
      q <= {W{1'b0}};
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule

/* File: core/pfs_pin_mux.v */
// two-way selector between a primary function and an lcd segment per pin
`timescale 1ns/1ns
module pfs_pin_mux #(
  parameter W = 1
) (
  // select: high picks primary
  input wire [W-1:0] sel_primary,
  // sources
  input wire [W-1:0] primary,
  input wire [W-1:0] segment,
  // result
  output wire [W-1:0] y
);
  assign y = (sel_primary & primary) | (~sel_primary & segment);
endmodule

/* File: tb/pfs_properties.sv */
// port assertions for the pin function block
`timescale 1ns/1ns
module pfs_checker (
  // clock and reset
  input wire clk,
  input wire rst,
  // register read path
  input wire rd,
  input wire [7:0] rdata,
  input wire irq,
  // button
  input wire push_button_input,
  input wire wake,
  // emulator pins
  input wire emulator_enable_pin,
  input wire emulator_data_in,
  input wire emulator_data_out,
  input wire emulator_data_oe_n,
  input wire emulator_clock_out,
  input wire emulator_reset_out,
  input wire [2:0] lcd_seg_emu,
  input wire [2:0] emu_pin_out,
  input wire [2:0] emu_pin_oe_n,
  input wire emulator_data_rx
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  AST_RST: assert property (disable iff (1'h0)
    rst |=> rdata == 8'h00 && !irq && !wake && emu_pin_oe_n == 3'h7) else $error("reset state");
  AST_RDATA_IDLE: assert property (!rd |=> rdata == 8'h00) else $error("rdata not idle");
  AST_WAKE_PULSE: assert property (wake |=> !wake) else $error("wake too long");
  AST_WAKE_CAUSE: assert property (
    wake |-> $past(push_button_input, 2) && !$past(push_button_input, 5)) else $error("wake cause");
  AST_EMU_ON: assert property (emulator_enable_pin [*4] |=>
    emu_pin_out == {$past(emulator_reset_out), $past(emulator_clock_out),
    $past(emulator_data_out)})
    else $error("emulator pins");
  AST_EMU_OE: assert property (emulator_enable_pin [*4] |=>
    emu_pin_oe_n == {2'h0, $past(emulator_data_oe_n)}) else $error("emulator enables");
  AST_EMU_RX: assert property (emulator_enable_pin [*4] |=>
    emulator_data_rx == $past(emulator_data_in)) else $error("emulator rx");
  AST_SEG: assert property (!emulator_enable_pin [*4] |=>
    emu_pin_out == $past(lcd_seg_emu) && emu_pin_oe_n == 3'h0 && !emulator_data_rx)
    else $error("segment pins");
  cover property (wake);
  cover property (emulator_enable_pin [*4]);
  cover property (rd ##1 rdata != 8'h00);
endmodule
bind pfs_top pfs_checker chk_i (.*);

/* File: tb/pfs_board.sv */
// board side: push button and emulator pod
`timescale 1ns/1ns
module pfs_board (
  // requests from the bench
  input wire clk,
  input wire press,
  input wire ice_on,
  // pins into the block
  output reg push_button_input,
  output reg emulator_enable_pin
);
  // button has no pull, so it is always driven low when idle
  initial push_button_input = 1'h0;
  initial emulator_enable_pin = 1'h0;
  always @(posedge clk) begin
    push_button_input <= press;
    emulator_enable_pin <= ice_on;
  end
endmodule

/* File: tb/tb_top.sv */
// self-checking bench for the pin function block
`timescale 1ns/1ns
`include "pfs_regs.vh"
module tb_top;
  reg clk = 1'h0, rst = 1'h1, wr = 1'h0, rd = 1'h0, press = 1'h0, ice_on = 1'h0;
  reg [3:0] addr = 4'h0;
  reg [7:0] wdata = 8'h00;
  reg emulator_data_in = 1'h1, emulator_data_out = 1'h0, emulator_data_oe_n = 1'h1;
  reg emulator_clock_out = 1'h1, emulator_reset_out = 1'h0, test_clock = 1'h1;
  reg frame_sync = 1'h1, lcd_seg_19 = 1'h0, lcd_seg_7 = 1'h0, uart_tx_led = 1'h1;
  reg optical_receive_pin = 1'h0, optical_transmit_pin = 1'h0;
  reg [2:0] lcd_seg_emu = 3'h5;
  reg [15:0] test_sources = 16'h0;
  wire [7:0] rdata;
  wire [2:0] emu_pin_out, emu_pin_oe_n;
  wire irq, emulator_data_rx, clock_test_output, multiplexer_frame_sync_output, wake;
  wire test_selector_pin, optical_receive_out, optical_receive_oe_n, uart_rx;
  wire optical_transmit_out, optical_transmit_oe_n, push_button_input, emulator_enable_pin;
  integer error_cnt = 0, n_compared = 0, i, n;
  always #50 clk = ~clk;
  pfs_top dut (.*);
  pfs_board board (.*);
  task chk(input [7:0] seen, input [7:0] exp, input [63:0] what);
    begin
      n_compared = n_compared + 1;
      if (seen !== exp) begin
        error_cnt = error_cnt + 1;
        $display("mismatch %0s exp %h seen %h", what, exp, seen);
      end
    end
  endtask
  // every task leaves time 1 ns after an edge
  task step(input integer k);
    begin
      repeat (k) @(posedge clk);
      #1;
    end
  endtask
  task wreg(input [3:0] a, input [7:0] d);
    begin
      addr <= a;
      wdata <= d;
      wr <= 1'h1;
      @(posedge clk);
      wr <= 1'h0;
      #1;
    end
  endtask
  task rreg(input [3:0] a, input [7:0] e);
    begin
      addr <= a;
      rd <= 1'h1;
      @(posedge clk);
      rd <= 1'h0;
      #1 chk(rdata, e, "rdata");
    end
  endtask
  task t_emu;
    begin
      step(4);
      chk({emulator_data_rx, emu_pin_oe_n, emu_pin_out}, 8'h05, "seg");
      ice_on <= 1'h1;
      step(5);
      chk({emulator_data_rx, emu_pin_oe_n, emu_pin_out}, 8'h4a, "emu");
      rreg(`PFS_OFF_WAKE, 8'h01);
      ice_on <= 1'h0;
      step(5);
      $display("emu done");
    end
  endtask
  task t_sel;
    begin
      for (i = 0; i < 4; i = i + 1) begin
        wreg(`PFS_OFF_CTRL, i[7:0]);
        step(3);
        chk({multiplexer_frame_sync_output, clock_test_output}, i[7:0], "ck");
      end
      rst <= 1'h1;
      step(2);
      rst <= 1'h0;
      rreg(`PFS_OFF_CTRL, 8'h00);
      for (i = 0; i < 16; i = i + 1) begin
        test_sources <= 16'h1 << i;
        wreg(`PFS_OFF_TSEL, i[7:0]);
        step(3);
        chk(test_selector_pin, 8'h01, "test_selector_field");
      end
      $display("sel done");
    end
  endtask
  task t_opt;
    begin
      step(3);
      chk({uart_rx, optical_receive_oe_n, optical_transmit_out, optical_transmit_oe_n},
        8'h06, "opt");
      wreg(`PFS_OFF_DIO_OUT, 8'h02);
      wreg(`PFS_OFF_DIO_DIR, 8'h03);
      wreg(`PFS_OFF_CTRL, 8'h0c);
      step(3);
      chk({optical_receive_out, optical_receive_oe_n, optical_transmit_out,
        optical_transmit_oe_n}, 8'h02, "dio");
      wreg(`PFS_OFF_DIO_DIR, 8'h00);
      optical_receive_pin <= 1'h1;
      step(4);
      rreg(`PFS_OFF_DIO_IN, 8'h01);
      $display("opt done");
    end
  endtask
  task t_btn;
    begin
      wreg(`PFS_OFF_CTRL, 8'h10);
      press <= 1'h1;
      n = 0;
      for (i = 0; i < 12; i = i + 1) begin
        step(1);
        n = n + wake;
      end
      chk(n[7:0], 8'h01, "wake");
      chk(irq, 8'h00, "mask");
      rreg(`PFS_OFF_STATUS, 8'h03);
      rreg(`PFS_OFF_CTRL, 8'h00);
      // second press in lcd-only state while the wake flag is still set
      press <= 1'h0;
      step(5);
      wreg(`PFS_OFF_CTRL, 8'h20);
      press <= 1'h1;
      n = 0;
      for (i = 0; i < 12; i = i + 1) begin
        step(1);
        n = n + wake;
      end
      chk(n[7:0], 8'h01, "wake2");
      rreg(`PFS_OFF_CTRL, 8'h00);
      wreg(`PFS_OFF_IRQ_EN, 8'h01);
      step(2);
      chk(irq, 8'h01, "irq");
      wreg(`PFS_OFF_CLEAR, 8'h03);
      step(2);
      chk(irq, 8'h00, "clr");
      rreg(`PFS_OFF_STATUS, 8'h00);
      rreg(4'hf, 8'h00);
      // a press outside the low-power states only sets the event flag
      press <= 1'h0;
      step(5);
      press <= 1'h1;
      n = 0;
      for (i = 0; i < 8; i = i + 1) begin
        step(1);
        n = n + wake;
      end
      chk(n[7:0], 8'h00, "nowake");
      rreg(`PFS_OFF_STATUS, 8'h01);
      chk(irq, 8'h01, "irq2");
      press <= 1'h0;
      $display("btn done");
    end
  endtask
  task stop_test;
    begin
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask
  initial begin
    step(8);
    chk({irq, wake, uart_rx, optical_receive_oe_n, optical_transmit_oe_n, emu_pin_oe_n},
      8'h3f, "rst");
    rst <= 1'h0;
    rreg(`PFS_OFF_TSEL, 8'h00);
    t_emu;
    t_sel;
    t_opt;
    t_btn;
    stop_test;
  end
endmodule
